// *** design/rcml_reset_ctrl.sv ***
// reset controller: source classification, pin drive and mode outputs
// How it works
// - reset input asserts at once; only its release passes a two-flop synchroniser.
// - four reset outputs: pin drive, clock unit, master, software system.
// - asynchronous sources assert reset at once, ignoring bus cycle.
// - synchronous sources wait for the current bus cycle to end.
// - bus monitor forced on while a synchronous reset is pending.
// - external and clock loss assert all three; test skips clock unit.
// - power-up, watchdog and halt are asynchronous, asserting all three.
// - reset instruction drives only the reset pin and software system reset, asynchronously.
// - reset is highest priority, taken at once if asynchronous, at bus cycle end if synchronous, no restart.
// - pending internal writes finish before synchronous reset acts.
// - first vector fetch address is zero, supervisor program space.
// - undriven mode pins read high, giving default configuration.
// - mode pin 0 low selects 8-bit boot port, high 16-bit.
// - boot chip-select is active as soon as reset releases.
// - pins 1 and 2 low convert chip-selects to arbitration and codes.
// - pins 3 to 7 thermometer-convert chip-selects into upper address.
// - mode pin 8 low moves bus control pins to port E.
// - mode pin 9 low moves interrupt and clock pins to port F.
// - mode pin 11 low enables factory test mode.
// - clock select high uses synthesizer, low external clock.
// - first bus cycle starts ten cycles after reset release.
// - any low breakpoint at release sets the background debug flag.
// - pin held low at least 512 cycles each time it is driven.
// - after drive, release ten cycles, test; low means drive again.
`include "rcml_map.svh"
module rcml_reset_ctrl
    import rcml_pkg::*;
#(
    parameter int HOLD_CYC = 512
)
(
    // clock, enable and reset
    input  wire logic                   MCLK_IN,
    input  wire logic                   RST_N_IN,
    input  wire logic                   CE_IN,
    // reset pin, open drain
    input  wire logic                   RESET_PIN_IN,
    output logic                        RESET_PIN_OUT,
    output logic                        RESET_PIN_OE_OUT,
    // reset sources
    input  wire logic                   POWER_UP_IN,
    input  wire logic                   WATCHDOG_IN,
    input  wire logic                   HALT_IN,
    input  wire logic                   CLOCK_LOSS_IN,
    input  wire logic                   TEST_RESET_IN,
    input  wire logic                   RESET_INSTR_IN,
    // bus status
    input  wire logic                   BUS_CYCLE_END_IN,
    input  wire logic                   BUS_BUSY_IN,
    input  wire logic                   WRITE_BUSY_IN,
    // mode pins
    input  wire logic [`RCML_MODE_W-1:0] DATA_IN,
    input  wire logic                   CLOCK_SOURCE_SELECT_IN,
    input  wire logic [1:0]             BREAKPOINT_IN,
    // reset lines
    output logic                        RESET_PIN_DRIVE_OUT,
    output logic                        CLOCK_UNIT_RESET_OUT,
    output logic                        MASTER_RESET_OUT,
    output logic                        SOFTWARE_SYSTEM_RESET_OUT,
    output logic                        BUS_MONITOR_FORCE_OUT,
    output logic                        ABORT_OUT,
    // boot and start
    output logic                        BOOT_CHIP_SELECT_OUT,
    output logic                        FIRST_BUS_CYCLE_OUT,
    output logic [23:0]                 VECTOR_ADDR_OUT,
    output logic                        SUPERVISOR_PROGRAM_OUT,
    // configuration
    output logic                        BOOT_8BIT_OUT,
    output logic                        ARB_PINS_OUT,
    output logic                        FUNCTION_CODE_PINS_OUT,
    output logic [4:0]                  ADDR_PINS_OUT,
    output logic                        GPIO_PORT_E_OUT,
    output logic                        GPIO_PORT_F_OUT,
    output logic                        TEST_MODE_OUT,
    output logic                        SYNTH_CLOCK_OUT,
    output logic                        BACKGROUND_DEBUG_FLAG_OUT
);
    typedef struct packed {
        logic        sync1;
        logic        sync2;
        rcml_state_t state;
        logic [9:0]  count;
        logic        pend_sync;
        logic        pend_clk;
        logic        mst;
        logic        clk;
        logic        pin;
        logic        sys;
        logic        mon;
        logic        abort;
        logic        boot_cs;
        logic        first;
        logic [3:0]  start_cnt;
    } rcml_st_t;

    rcml_st_t   st_reg;
    rcml_st_t   st_next;
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    rcml_cfg_if cfg_bus ();

    // release of the reset input through two flops
    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    rcml_mode_latch u_latch (
        .clk_in                 (MCLK_IN),
        .rst_n_in               (rst_n),
        .ce_in                  (CE_IN),
        .data_in                (DATA_IN),
        .clock_source_select_in (CLOCK_SOURCE_SELECT_IN),
        .breakpoint_in          (BREAKPOINT_IN),
        .cfg_port               (cfg_bus.latch)
    );

    // hardware catastrophic sources, never deferred
    logic async_hard;
    logic sync_req;
    logic sync_clk;
    logic pin_low;
    logic cycle_done;
    assign async_hard = POWER_UP_IN | WATCHDOG_IN | HALT_IN;
    assign sync_clk   = pin_low | CLOCK_LOSS_IN;
    assign pin_low    = ~st_reg.sync2;
    assign sync_req   = pin_low | CLOCK_LOSS_IN | TEST_RESET_IN;
    // a cycle ends with the bus and no write left half done
    assign cycle_done = (BUS_CYCLE_END_IN | ~BUS_BUSY_IN)
                        & ~WRITE_BUSY_IN;

    // synchroniser first stage is read only by the second
    always_comb
    begin
        st_next = st_reg;
        st_next.sync1 = RESET_PIN_IN;
        st_next.sync2 = st_reg.sync1;
        st_next.first = 1'b0;
        st_next.sys   = RESET_INSTR_IN;
        cfg_bus.capture = 1'b0;
        case (st_reg.state)
            RCML_IDLE, RCML_BOOT:
            begin
                if (st_reg.state == RCML_BOOT && st_reg.start_cnt != 4'h0)
                begin
                    st_next.start_cnt = st_reg.start_cnt - 4'h1;
                    if (st_reg.start_cnt == 4'h1)
                        st_next.first = 1'b1;
                end
                if (async_hard)
                begin
                    // immediate, whatever the bus is doing
                    st_next.mst   = 1'b1;
                    st_next.clk   = 1'b1;
                    st_next.pin   = 1'b1;
                    st_next.abort = 1'b1;
                    st_next.boot_cs = 1'b0;
                    st_next.count = 10'h0;
                    st_next.state = RCML_DRIVE;
                end
                else if (sync_req)
                begin
                    st_next.pend_sync = 1'b1;
                    st_next.pend_clk  = sync_clk;
                    st_next.mon   = 1'b1;
                    st_next.state = RCML_WAIT_BUS;
                end
                else if (RESET_INSTR_IN)
                begin
                    // pin only, processor keeps running
                    st_next.pin   = 1'b1;
                    st_next.count = 10'h0;
                    st_next.state = RCML_DRIVE;
                end
            end
            RCML_WAIT_BUS:
            begin
                if (sync_clk)
                    st_next.pend_clk = 1'b1;
                if (async_hard || cycle_done)
                begin
                    st_next.mst   = 1'b1;
                    st_next.clk   = st_reg.pend_clk | async_hard;
                    st_next.pin   = 1'b1;
                    st_next.mon   = 1'b0;
                    st_next.abort = 1'b1;
                    st_next.boot_cs = 1'b0;
                    st_next.pend_sync = 1'b0;
                    st_next.count = 10'h0;
                    st_next.state = RCML_DRIVE;
                end
            end
            RCML_DRIVE:
            begin
                if (async_hard)
                begin
                    st_next.mst = 1'b1;
                    st_next.clk = 1'b1;
                    st_next.abort = 1'b1;
                    st_next.boot_cs = 1'b0;
                end
                // hold at least the full time and while an asynchronous source or the reset instruction persists
                if (st_reg.count >= 10'(HOLD_CYC - 1))
                begin
                    if (!(async_hard | RESET_INSTR_IN))
                    begin
                        st_next.pin   = 1'b0;
                        st_next.count = 10'h0;
                        st_next.state = RCML_RELEASE;
                    end
                end
                else
                    st_next.count = st_reg.count + 10'h1;
            end
            RCML_RELEASE:
            begin
                if (async_hard)
                begin
                    // catastrophic source cuts the float window short
                    st_next.mst   = 1'b1;
                    st_next.clk   = 1'b1;
                    st_next.pin   = 1'b1;
                    st_next.abort = 1'b1;
                    st_next.boot_cs = 1'b0;
                    st_next.count = 10'h0;
                    st_next.state = RCML_DRIVE;
                end
                else if (st_reg.count >= `RCML_RELEASE_CYC - 10'h1)
                begin
                    st_next.count = 10'h0;
                    if (pin_low || async_hard)
                    begin
                        st_next.pin   = 1'b1;
                        st_next.state = RCML_DRIVE;
                    end
                    else
                    begin
                        // release: latch mode pins if master reset was on, open boot memory
                        cfg_bus.capture = st_reg.mst;
                        st_next.mst   = 1'b0;
                        st_next.clk   = 1'b0;
                        st_next.abort = 1'b0;
                        st_next.boot_cs = 1'b1;
                        st_next.start_cnt = 4'(`RCML_FIRST_BUS_CYC);
                        st_next.state = RCML_BOOT;
                    end
                end
                else
                    st_next.count = st_reg.count + 10'h1;
            end
            default:
                st_next.state = RCML_IDLE;
        endcase
    end

    // reset asserts master lines so the device boots after release
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg       <= '0;
            st_reg.sync1 <= 1'b1;
            st_reg.sync2 <= 1'b1;
            st_reg.mst   <= 1'b1;
            st_reg.clk   <= 1'b1;
            st_reg.pin   <= 1'b1;
            st_reg.abort <= 1'b1;
            st_reg.state <= RCML_DRIVE;
        end
        else if (CE_IN)
            st_reg <= st_next;
    end

    // configuration and reset outputs straight from flops
    logic [8:0] cfg_out_reg;
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
            cfg_out_reg <= 9'h0;
        else if (CE_IN)
            cfg_out_reg <= {cfg_bus.cfg.port_e, cfg_bus.cfg.port_f,
                            cfg_bus.cfg.test_mode, cfg_bus.cfg.synth_clock,
                            cfg_bus.cfg.debug_flag, cfg_bus.cfg.boot_8bit,
                            cfg_bus.cfg.arb_pins, cfg_bus.cfg.func_code_pins,
                            1'b0};
    end

    logic [4:0] addr_out_reg;
    always_ff @(posedge MCLK_IN or negedge rst_n)
    begin
        if (!rst_n)
            addr_out_reg <= 5'h0;
        else if (CE_IN)
            addr_out_reg <= cfg_bus.cfg.addr_pins;
    end

    // open drain: drive low only, enable high while driving
    assign RESET_PIN_OUT             = 1'b0;
    assign RESET_PIN_OE_OUT          = st_reg.pin;
    assign RESET_PIN_DRIVE_OUT       = st_reg.pin;
    assign CLOCK_UNIT_RESET_OUT      = st_reg.clk;
    assign MASTER_RESET_OUT          = st_reg.mst;
    assign SOFTWARE_SYSTEM_RESET_OUT = st_reg.sys;
    assign BUS_MONITOR_FORCE_OUT     = st_reg.mon;
    assign ABORT_OUT                 = st_reg.abort;
    assign BOOT_CHIP_SELECT_OUT      = st_reg.boot_cs;
    assign FIRST_BUS_CYCLE_OUT       = st_reg.first;
    assign VECTOR_ADDR_OUT           = `RCML_VECTOR_ADDR;
    assign SUPERVISOR_PROGRAM_OUT    = 1'b1;
    assign GPIO_PORT_E_OUT           = cfg_out_reg[8];
    assign GPIO_PORT_F_OUT           = cfg_out_reg[7];
    assign TEST_MODE_OUT             = cfg_out_reg[6];
    assign SYNTH_CLOCK_OUT           = cfg_out_reg[5];
    assign BACKGROUND_DEBUG_FLAG_OUT = cfg_out_reg[4];
    assign BOOT_8BIT_OUT             = cfg_out_reg[3];
    assign ARB_PINS_OUT              = cfg_out_reg[2];
    assign FUNCTION_CODE_PINS_OUT    = cfg_out_reg[1];
    assign ADDR_PINS_OUT             = addr_out_reg;
endmodule

// *** pkg/rcml_map.svh ***
// constants for the reset control and mode latch block
`ifndef RCML_MAP_SVH
`define RCML_MAP_SVH
`define RCML_PIN_HOLD_CYC   10'd512
`define RCML_RELEASE_CYC    10'd10
`define RCML_FIRST_BUS_CYC  10'd10
`define RCML_VECTOR_ADDR    24'h000000
`define RCML_MODE_W         16
`define RCML_BOOT8_BIT      0
`define RCML_ARB_BIT        1
`define RCML_FUNC_CODE_BIT  2
`define RCML_ADDR_LO_BIT    3
`define RCML_ADDR_HI_BIT    7
`define RCML_PORT_E_BIT     8
`define RCML_PORT_F_BIT     9
`define RCML_TEST_BIT       11
`endif

// *** pkg/rcml_pkg.sv ***
// types for the reset control and mode latch block
package rcml_pkg;
    typedef enum logic [2:0] {
        RCML_IDLE,
        RCML_WAIT_BUS,
        RCML_DRIVE,
        RCML_RELEASE,
        RCML_BOOT
    } rcml_state_t;
    typedef struct packed {
        logic       boot_8bit;
        logic       arb_pins;
        logic       func_code_pins;
        logic [4:0] addr_pins;
        logic       port_e;
        logic       port_f;
        logic       test_mode;
        logic       synth_clock;
        logic       debug_flag;
    } rcml_cfg_t;
endpackage

// *** pkg/rcml_cfg_if.sv ***
// carries latched configuration from the latch to the controller
interface rcml_cfg_if;
    import rcml_pkg::*;
    logic      capture;
    rcml_cfg_t cfg;
    modport latch (input capture, output cfg);
    modport ctrl  (output capture, input cfg);
endinterface

// *** design/rcml_mode_latch.sv ***
// mode-select latch captured at reset release
`include "rcml_map.svh"
module rcml_mode_latch
    import rcml_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   ce_in,
    // sampled pins
    input  wire logic [`RCML_MODE_W-1:0] data_in,
    input  wire logic                   clock_source_select_in,
    input  wire logic [1:0]             breakpoint_in,
    // to controller
    rcml_cfg_if.latch                   cfg_port
);
    rcml_cfg_t cfg_reg;
    rcml_cfg_t cfg_next;

    // data and breakpoint pins are active low: low picks the alternate function; clock select is not inverted
    always_comb
    begin
        cfg_next = cfg_reg;
        if (cfg_port.capture)
        begin
            cfg_next.boot_8bit   = ~data_in[`RCML_BOOT8_BIT];
            cfg_next.arb_pins    = ~data_in[`RCML_ARB_BIT];
            cfg_next.func_code_pins = ~data_in[`RCML_FUNC_CODE_BIT];
            cfg_next.port_e      = ~data_in[`RCML_PORT_E_BIT];
            cfg_next.port_f      = ~data_in[`RCML_PORT_F_BIT];
            cfg_next.test_mode   = ~data_in[`RCML_TEST_BIT];
            cfg_next.synth_clock = clock_source_select_in;
            cfg_next.debug_flag  = ~(&breakpoint_in);
            // thermometer: a low pin also converts all lower selects
            for (int i = 0; i < 5; i++)
            begin
                cfg_next.addr_pins[i] = 1'b0;
                for (int j = `RCML_ADDR_LO_BIT + i;
                     j <= `RCML_ADDR_HI_BIT; j++)
                    cfg_next.addr_pins[i] =
                        cfg_next.addr_pins[i] | ~data_in[j];
            end
        end
    end

    // reset configuration matches all pins pulled high, except synth_clock, which resets low
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cfg_reg <= '0;
        else if (ce_in)
            cfg_reg <= cfg_next;
    end

    assign cfg_port.cfg = cfg_reg;
endmodule

// *** verification/rcml_partner.sv ***
// model of the reset pin source and mode pin conditioning logic
module rcml_partner
(
    // controller side
    input  wire logic        clk_in,
    input  wire logic        oe_in,
    input  wire logic        master_in,
    // test control
    input  wire logic        ext_rst_in,
    input  wire logic [15:0] mode_in,
    input  wire logic        sel_in,
    input  wire logic [1:0]  brk_in,
    // pins seen by the controller
    output logic             pin_out,
    output logic [15:0]      data_out,
    output logic             sel_out,
    output logic [1:0]       brk_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hist_reg;
    logic       drive;
    // remember master reset for two cycles after it falls
    always_ff @(posedge clk_in)
        hist_reg <= {hist_reg[0], master_in};
    // let go well before the first bus cycle to avoid contention
    assign drive = master_in | hist_reg[0] | hist_reg[1];
    // open drain pin with pull-up
    assign pin_out = !(oe_in | ext_rst_in);
    assign data_out = drive ? mode_in : 16'hffff;
    // no pull-up here, so show the inverse once released
    assign sel_out = drive ? sel_in : ~sel_in;
    assign brk_out = drive ? brk_in : ~brk_in;
endmodule

// *** verification/rcml_chk.sv ***
// concurrent checks on the reset controller ports
module rcml_chk
#(
    parameter int HOLD_CYC = 512
)
(
    // clock, reset and sources
    input wire logic       MCLK_IN,
    input wire logic       RST_N_IN,
    input wire logic       CE_IN,
    input wire logic       POWER_UP_IN,
    input wire logic       WATCHDOG_IN,
    input wire logic       HALT_IN,
    input wire logic       RESET_INSTR_IN,
    // bus status
    input wire logic       BUS_CYCLE_END_IN,
    input wire logic       BUS_BUSY_IN,
    input wire logic       WRITE_BUSY_IN,
    // controller outputs
    input wire logic       RESET_PIN_OE_OUT,
    input wire logic       RESET_PIN_DRIVE_OUT,
    input wire logic       CLOCK_UNIT_RESET_OUT,
    input wire logic       MASTER_RESET_OUT,
    input wire logic       SOFTWARE_SYSTEM_RESET_OUT,
    input wire logic       BUS_MONITOR_FORCE_OUT,
    input wire logic       ABORT_OUT,
    input wire logic       BOOT_CHIP_SELECT_OUT,
    input wire logic       FIRST_BUS_CYCLE_OUT,
    input wire logic [4:0] ADDR_PINS_OUT,
    input wire logic       BOOT_8BIT_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        any_async;
    logic [15:0] oe_cnt_reg;
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    assign any_async = POWER_UP_IN | WATCHDOG_IN | HALT_IN;
    // length of the current drive burst, cleared while floating
    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            oe_cnt_reg <= 16'h0000;
        else if (RESET_PIN_OE_OUT)
            oe_cnt_reg <= oe_cnt_reg + 16'h0001;
        else
            oe_cnt_reg <= 16'h0000;
    end
    sequence s_float;
        (!RESET_PIN_OE_OUT) [*8] ##1 (!RESET_PIN_OE_OUT) [*2];
    endsequence
    sequence s_start;
        (!FIRST_BUS_CYCLE_OUT) [*8] ##1 !FIRST_BUS_CYCLE_OUT
            ##1 FIRST_BUS_CYCLE_OUT;
    endsequence
    property p_async;
        CE_IN && any_async |=> MASTER_RESET_OUT && CLOCK_UNIT_RESET_OUT
            && RESET_PIN_DRIVE_OUT;
    endproperty
    a_async: assert property (p_async) else $error("async late");
    property p_instr;
        CE_IN && RESET_INSTR_IN && BOOT_CHIP_SELECT_OUT && !any_async
            && !MASTER_RESET_OUT && !RESET_PIN_DRIVE_OUT
            |=> RESET_PIN_DRIVE_OUT && !MASTER_RESET_OUT
            && !CLOCK_UNIT_RESET_OUT;
    endproperty
    a_instr: assert property (p_instr) else $error("instr lines");
    property p_swrst;
        CE_IN && RESET_INSTR_IN |=> SOFTWARE_SYSTEM_RESET_OUT;
    endproperty
    a_swrst: assert property (p_swrst) else $error("no sw reset");
    property p_defer;
        BUS_MONITOR_FORCE_OUT && !MASTER_RESET_OUT && WRITE_BUSY_IN
            && !any_async |=> !MASTER_RESET_OUT;
    endproperty
    a_defer: assert property (p_defer) else $error("early");
    property p_go;
        CE_IN && BUS_MONITOR_FORCE_OUT && !MASTER_RESET_OUT && !WRITE_BUSY_IN
            && (BUS_CYCLE_END_IN || !BUS_BUSY_IN)
            |=> MASTER_RESET_OUT && RESET_PIN_DRIVE_OUT;
    endproperty
    a_go: assert property (p_go) else $error("sync late");
    property p_boot;
        $rose(BOOT_CHIP_SELECT_OUT) |-> !MASTER_RESET_OUT ##1 s_start;
    endproperty
    a_boot: assert property (p_boot) else $error("start timing");
    property p_float;
        $fell(RESET_PIN_OE_OUT) |-> s_float;
    endproperty
    a_float: assert property (p_float) else $error("float short");
    property p_hold;
        $fell(RESET_PIN_OE_OUT) |-> oe_cnt_reg >= HOLD_CYC;
    endproperty
    a_hold: assert property (p_hold) else $error("drive short");
    property p_cfg;
        !MASTER_RESET_OUT && !$past(MASTER_RESET_OUT)
            && !$past(MASTER_RESET_OUT, 2)
            |-> $stable({ADDR_PINS_OUT, BOOT_8BIT_OUT});
    endproperty
    a_cfg: assert property (p_cfg) else $error("cfg moved");
    property p_abort;
        ABORT_OUT == MASTER_RESET_OUT;
    endproperty
    a_abort: assert property (p_abort) else $error("abort");
endmodule
bind rcml_reset_ctrl rcml_chk #(.HOLD_CYC(HOLD_CYC)) rcml_chk_inst
(
    .MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN),
    .POWER_UP_IN(POWER_UP_IN), .WATCHDOG_IN(WATCHDOG_IN), .HALT_IN(HALT_IN),
    .RESET_INSTR_IN(RESET_INSTR_IN), .BUS_CYCLE_END_IN(BUS_CYCLE_END_IN),
    .BUS_BUSY_IN(BUS_BUSY_IN), .WRITE_BUSY_IN(WRITE_BUSY_IN),
    .RESET_PIN_OE_OUT(RESET_PIN_OE_OUT),
    .RESET_PIN_DRIVE_OUT(RESET_PIN_DRIVE_OUT),
    .CLOCK_UNIT_RESET_OUT(CLOCK_UNIT_RESET_OUT),
    .MASTER_RESET_OUT(MASTER_RESET_OUT),
    .SOFTWARE_SYSTEM_RESET_OUT(SOFTWARE_SYSTEM_RESET_OUT),
    .BUS_MONITOR_FORCE_OUT(BUS_MONITOR_FORCE_OUT), .ABORT_OUT(ABORT_OUT),
    .BOOT_CHIP_SELECT_OUT(BOOT_CHIP_SELECT_OUT),
    .FIRST_BUS_CYCLE_OUT(FIRST_BUS_CYCLE_OUT),
    .ADDR_PINS_OUT(ADDR_PINS_OUT), .BOOT_8BIT_OUT(BOOT_8BIT_OUT)
);

// *** verification/tb.sv ***
// testbench for the reset controller and mode latch
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 16;
    logic        mclk = 1'b0, rst_n = 1'b0, ext = 1'b0, sel = 1'b1;
    logic        pwr = 1'b0, wdog = 1'b0, halt = 1'b0, closs = 1'b0;
    logic        trst = 1'b0, instr = 1'b0, bend = 1'b0, ce = 1'b1;
    logic        bbusy = 1'b0, wbusy = 1'b0, pin, csel;
    logic [15:0] mode = 16'hffff, data;
    logic [1:0]  brk = 2'h3, brkp;
    logic        oe, pdrv, cur, mst, swr, mon, bcs, fbc, sup;
    logic        b8, arb, fcode, pe, pf, tm, syn, dbg;
    logic [4:0]  addr;
    logic [23:0] vec;
    logic [12:0] cfg_seen;
    int          n_fail = 0, n_tests = 0;
    // one row per reset scenario
    logic [15:0] mt[6] = '{16'h0000, 16'hf6a5, 16'hfdff, 16'h7b5a,
                           16'hfff7, 16'hefbf};
    logic        st[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [1:0]  bt[6] = '{2'h0, 2'h2, 2'h1, 2'h3, 2'h0, 2'h1};
    assign cfg_seen = {b8, arb, fcode, addr, pe, pf, tm, syn, dbg};
    rcml_reset_ctrl #(.HOLD_CYC(HOLD)) rcml_reset_ctrl_inst (
        .MCLK_IN(mclk), .RST_N_IN(rst_n), .CE_IN(ce),
        .RESET_PIN_IN(pin), .RESET_PIN_OUT(), .RESET_PIN_OE_OUT(oe),
        .POWER_UP_IN(pwr), .WATCHDOG_IN(wdog), .HALT_IN(halt),
        .CLOCK_LOSS_IN(closs), .TEST_RESET_IN(trst), .RESET_INSTR_IN(instr),
        .BUS_CYCLE_END_IN(bend), .BUS_BUSY_IN(bbusy), .WRITE_BUSY_IN(wbusy),
        .DATA_IN(data), .CLOCK_SOURCE_SELECT_IN(csel), .BREAKPOINT_IN(brkp),
        .RESET_PIN_DRIVE_OUT(pdrv), .CLOCK_UNIT_RESET_OUT(cur),
        .MASTER_RESET_OUT(mst), .SOFTWARE_SYSTEM_RESET_OUT(swr),
        .BUS_MONITOR_FORCE_OUT(mon), .ABORT_OUT(),
        .BOOT_CHIP_SELECT_OUT(bcs), .FIRST_BUS_CYCLE_OUT(fbc),
        .VECTOR_ADDR_OUT(vec), .SUPERVISOR_PROGRAM_OUT(sup),
        .BOOT_8BIT_OUT(b8), .ARB_PINS_OUT(arb), .FUNCTION_CODE_PINS_OUT(fcode),
        .ADDR_PINS_OUT(addr), .GPIO_PORT_E_OUT(pe), .GPIO_PORT_F_OUT(pf),
        .TEST_MODE_OUT(tm), .SYNTH_CLOCK_OUT(syn),
        .BACKGROUND_DEBUG_FLAG_OUT(dbg));
    rcml_partner rcml_partner_inst (
        .clk_in(mclk), .oe_in(oe), .master_in(mst), .ext_rst_in(ext),
        .mode_in(mode), .sel_in(sel), .brk_in(brk), .pin_out(pin),
        .data_out(data), .sel_out(csel), .brk_out(brkp));
    always #5 mclk = ~mclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // all driving and looking happens on the falling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // low pin k turns address bits 19 up to 19+k-3 on
    function automatic logic [12:0] cfg_exp(logic [15:0] d, logic s,
                                            logic [1:0] b);
        logic [4:0] a;
        a = 5'h00;
        for (int i = 0; i < 5; i++)
            for (int j = i; j < 5; j++)
                a[i] = a[i] | ~d[3+j];
        return {~d[0], ~d[1], ~d[2], a, ~d[8], ~d[9], ~d[11], s, ~&b};
    endfunction
    task automatic wait_boot(input int k);
        int i;
        i = 0;
        while (!(bcs === 1'b1 && mst === 1'b0) && i < 3000)
        begin
            cyc(1);
            i++;
        end
        chk(i < 3000, 1);
        cyc(2);
        chk(cfg_seen, cfg_exp(mode, sel, brk));
        cyc(12);
        chk(cfg_seen, cfg_exp(mode, sel, brk));
        $display("test %0d done", k);
    endtask
    task automatic run(input int k);
        mode = mt[k];
        sel = st[k];
        brk = bt[k];
        cyc(1);
        if (k == 0)
        begin
            ext = 1'b1;
            cyc(HOLD + 40);
            chk({mst, cur}, 2'h3);
            ext = 1'b0;
        end
        else if (k < 3)
        begin
            bbusy = 1'b1;
            wbusy = 1'b1;
            trst = (k == 1);
            closs = (k == 2);
            cyc(3);
            chk({mon, mst}, 2'h2);
            wbusy = 1'b0;
            cyc(3);
            chk(mst, 0);
            bend = 1'b1;
            cyc(1);
            bend = 1'b0;
            bbusy = 1'b0;
            cyc(1);
            chk({mst, pdrv, cur}, {2'h3, k == 2});
            trst = 1'b0;
            closs = 1'b0;
        end
        else
        begin
            bbusy = 1'b1;
            wbusy = 1'b1;
            wdog = (k == 3);
            pwr = (k == 4);
            halt = (k == 5);
            cyc(1);
            chk({mst, cur, pdrv}, 3'h7);
            {wdog, pwr, halt, bbusy, wbusy} = 5'h00;
        end
        wait_boot(k);
    endtask
    initial
    begin
        #100us;
        n_fail++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        final_report();
    end
    task automatic final_report();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        cyc(6);
        rst_n = 1'b1;
        wait_boot(9);
        chk({sup, vec}, 25'h1000000);
        for (int k = 0; k < 6; k++)
            run(k);
        // reset instruction: pin and software reset only, no new capture
        // enable low: the request must wait until it rises
        ce = 1'b0;
        instr = 1'b1;
        cyc(2);
        chk({pdrv, swr}, 2'h0);
        ce = 1'b1;
        cyc(1);
        instr = 1'b0;
        chk({pdrv, mst, cur, swr}, 4'h9);
        cyc(HOLD + 40);
        chk({oe, mst}, 2'h0);
        chk(cfg_seen, cfg_exp(mode, sel, brk));
        $display("test instr done");
        final_report();
    end
endmodule
